/* verilog/pdoc_pkg.sv */
package pdoc_pkg;

    localparam int          ADDR_W              = 16;
    localparam int          DATA_W              = 8;
    localparam int          FB_W                = 12;
    localparam int          REFM_W              = 4;
    localparam int          DIVA_W              = 8;
    localparam int          MODE_W              = 3;
    localparam int          POL_W               = 2;

    // Register offsets
    localparam logic [15:0] ADDR_IO_UPDATE      = 16'h0005;
    localparam logic [15:0] ADDR_FB_LOW         = 16'h010D;
    localparam logic [15:0] ADDR_FB_HIGH        = 16'h010E;
    localparam logic [15:0] ADDR_REF_M          = 16'h010F;
    localparam logic [15:0] ADDR_DIV_A          = 16'h0110;
    localparam logic [15:0] ADDR_OUT0_CFG       = 16'h0111;

    // Field positions
    localparam int          IO_UPDATE_BIT       = 0;
    localparam int          FB_HIGH_LSB         = 0;
    localparam int          FB_HIGH_W           = 4;
    localparam int          FB_SPLIT            = 8;
    localparam int          OUT_PD_BIT          = 0;
    localparam int          OUT_POL_LSB         = 1;
    localparam int          OUT_MODE_LSB        = 3;

    // Reset values
    localparam logic [7:0]  RST_FB_LOW          = 8'h00;
    localparam logic [7:0]  RST_FB_HIGH         = 8'h00;
    localparam logic [7:0]  RST_REF_M           = 8'h00;
    localparam logic [7:0]  RST_DIV_A           = 8'h00;
    localparam logic [7:0]  RST_OUT0_CFG        = 8'h00;

    // Divider code ranges
    localparam logic [11:0] FB_BYPASS_MAX       = 12'h001;
    localparam logic [3:0]  REFM_DIV_MIN        = 4'h3;
    localparam logic [3:0]  REFM_DIV_MAX        = 4'hB;
    localparam logic [3:0]  REFM_NOCAL_MIN      = 4'hC;
    localparam logic [3:0]  REFM_NOCAL_MAX      = 4'hE;
    localparam logic [3:0]  REFM_RESET_STATE    = 4'hF;

    // Loop configurations one to four, coded from zero
    localparam logic [1:0]  LOOP_CFG_2          = 2'h1;
    localparam logic [1:0]  LOOP_CFG_4          = 2'h3;

    // Driver logic modes
    localparam logic [2:0]  MODE_DISABLED       = 3'h0;
    localparam logic [2:0]  MODE_HSTL           = 3'h1;
    localparam logic [2:0]  MODE_CMOS_BOTH      = 3'h4;
    localparam logic [2:0]  MODE_CMOS_TRUE      = 3'h5;
    localparam logic [2:0]  MODE_CMOS_COMP      = 3'h6;

    // Polarity codes
    localparam logic [1:0]  POL_NORM_INV        = 2'h0;
    localparam logic [1:0]  POL_NORM_NORM       = 2'h1;
    localparam logic [1:0]  POL_INV_INV         = 2'h2;
    localparam logic [1:0]  POL_INV_NORM        = 2'h3;

endpackage

/* verilog/pdoc_top.sv */
// Functional notes
// R1 - Feedback B value 0 or 1 bypasses that divider and forbids loop configuration two.
// R2 - Feedback B values 4 to 4095 divide by value; 2 and 3 undefined.
// R3 - Loop configuration four always bypasses the feedback B divider.
// R4 - Feedback B bits 11 to 8 sit in the low nibble of its high register.
// R5 - Reference M values 0 to 2 disable it; 3 to 11 divide by value.
// R6 - Reference M values 12 to 14 skip oscillator calibration after a change.
// R7 - Software writes 15 and updates, then new value and updates, to avoid calibration.
// R8 - Writing 1 to bit 0 at 0x0005 makes staged settings take effect.
// R9 - Software may skip the 15 sequence when it runs a calibration afterwards.
// R10 - Group A divider divides by value plus one; zero passes undivided.
// R11 - Group A divider powers down when all four drivers are off.
// R12 - Logic mode 000 disabled, 001 HSTL; 010, 011, 111 undefined.
// R13 - CMOS mode 100 drives both pins, 101 true only, 110 complement only.
// R14 - Polarity affects CMOS only; 00 gives true normal, complement inverted.
// R15 - Polarity 01 both normal, 10 both inverted, 11 true inverted only.
// R16 - Driver power-down bit 0 keeps driver active, 1 powers it down.
// R17 - Software never programs undefined feedback B or logic mode codes.
`timescale 1ns/1ps
module pdoc_top
    import pdoc_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int DATA_WIDTH = DATA_W
)
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic [ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [DATA_WIDTH-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [DATA_WIDTH-1:0] reg_rdata,
    input  wire logic [1:0]            loop_config,
    input  wire logic [2:0]            other_drivers_off,
    input  wire logic                  vco_cal_done,
    output logic                       io_update_pulse,
    output logic                       loop2_allowed,
    output logic                       feedback_b_bypass,
    output logic                       feedback_b_tick,
    output logic                       reference_m_enabled,
    output logic                       reference_m_tick,
    output logic                       vco_cal_request,
    output logic                       group_a_divider_powered,
    output logic                       group_a_tick,
    output logic                       first_output_true_pin,
    output logic                       first_output_true_pin_en,
    output logic                       first_output_complement_pin,
    output logic                       first_output_complement_pin_en
);

    // Staged register images, written by software
    logic [7:0]          fb_low_r;
    logic [7:0]          fb_high_r;
    logic [7:0]          ref_m_r;
    logic [7:0]          div_a_r;
    logic [7:0]          out0_cfg_r;

    // Active settings, loaded on an update
    logic [FB_W-1:0]     fb_act_r;
    logic [REFM_W-1:0]   refm_act_r;
    logic [DIVA_W-1:0]   diva_act_r;
    logic [MODE_W-1:0]   mode_act_r;
    logic [POL_W-1:0]    pol_act_r;
    logic                pd_act_r;

    logic                upd_r;
    logic                wr_hit_upd;
    logic [FB_W-1:0]     fb_staged;
    logic [DATA_WIDTH-1:0] rdata_r;
    logic [DATA_WIDTH-1:0] rdata_nxt;

    logic [FB_W-1:0]     fb_cnt_r;
    logic                fb_tick_r;
    logic [REFM_W-1:0]   refm_cnt_r;
    logic                refm_tick_r;
    logic [DIVA_W-1:0]   diva_cnt_r;
    logic                diva_tick_r;
    logic                cal_pend_r;
    logic                cal_trigger;

    logic                fb_bypass;
    logic                refm_divides;
    logic                drv0_off;
    logic                diva_powered;
    logic                cmos_mode;
    logic                true_en;
    logic                comp_en;
    logic                true_inv;
    logic                comp_inv;
    logic                true_r;
    logic                comp_r;

    // Register writes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            fb_low_r   <= RST_FB_LOW;
            fb_high_r  <= RST_FB_HIGH;
            ref_m_r    <= RST_REF_M;
            div_a_r    <= RST_DIV_A;
            out0_cfg_r <= RST_OUT0_CFG;
        end
        else if (reg_wr)
        begin
            case (reg_addr[15:0])
                ADDR_FB_LOW:   fb_low_r   <= reg_wdata;
                ADDR_FB_HIGH:  fb_high_r  <= {4'h0, reg_wdata[FB_HIGH_LSB +: FB_HIGH_W]}; // see R4
                ADDR_REF_M:    ref_m_r    <= {4'h0, reg_wdata[REFM_W-1:0]};
                ADDR_DIV_A:    div_a_r    <= reg_wdata;
                ADDR_OUT0_CFG: out0_cfg_r <= {2'h0, reg_wdata[5:0]};
                default:       ;
            endcase
        end
    end

    // Low nibble of the high register carries bits 11 to 8
    assign fb_staged = {fb_high_r[FB_HIGH_LSB +: FB_HIGH_W], fb_low_r[FB_SPLIT-1:0]}; // see R4

    // The update bit is self-clearing and always reads back zero
    assign wr_hit_upd = reg_wr && (reg_addr[15:0] == ADDR_IO_UPDATE) && reg_wdata[IO_UPDATE_BIT]; // see R8

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            upd_r <= 1'b0;
        else
            upd_r <= wr_hit_upd; // see R8
    end

    // Staged values reach the dividers only on an update
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            fb_act_r   <= {RST_FB_HIGH[3:0], RST_FB_LOW};
            refm_act_r <= RST_REF_M[REFM_W-1:0];
            diva_act_r <= RST_DIV_A;
            mode_act_r <= RST_OUT0_CFG[OUT_MODE_LSB +: MODE_W];
            pol_act_r  <= RST_OUT0_CFG[OUT_POL_LSB +: POL_W];
            pd_act_r   <= RST_OUT0_CFG[OUT_PD_BIT];
        end
        else if (upd_r)
        begin
            fb_act_r   <= fb_staged; // see R8
            refm_act_r <= ref_m_r[REFM_W-1:0];
            diva_act_r <= div_a_r;
            mode_act_r <= out0_cfg_r[OUT_MODE_LSB +: MODE_W];
            pol_act_r  <= out0_cfg_r[OUT_POL_LSB +: POL_W];
            pd_act_r   <= out0_cfg_r[OUT_PD_BIT];
        end
    end

    // Read data is registered; unmapped offsets read zero
    always_comb
    begin
        rdata_nxt = '0;
        case (reg_addr[15:0])
            ADDR_FB_LOW:   rdata_nxt = fb_low_r;
            ADDR_FB_HIGH:  rdata_nxt = fb_high_r;
            ADDR_REF_M:    rdata_nxt = ref_m_r;
            ADDR_DIV_A:    rdata_nxt = div_a_r;
            ADDR_OUT0_CFG: rdata_nxt = out0_cfg_r;
            default:       rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rdata_r <= '0;
        else if (reg_rd)
            rdata_r <= rdata_nxt;
    end

    // Feedback B divider
    assign fb_bypass = (fb_act_r <= FB_BYPASS_MAX) // see R1
                    || (loop_config == LOOP_CFG_4); // see R3

    // Values 2 and 3 are left to divide by their value
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            {fb_cnt_r, fb_tick_r} <= '0;
        else if (fb_bypass || upd_r)
        begin
            fb_cnt_r  <= '0;
            fb_tick_r <= fb_bypass; // see R1
        end
        else if (fb_cnt_r >= fb_act_r - 12'h001)
        begin
            fb_cnt_r  <= '0;
            fb_tick_r <= 1'b1; // see R2
        end
        else
        begin
            fb_cnt_r  <= fb_cnt_r + 12'h001;
            fb_tick_r <= 1'b0;
        end
    end

    // Reference M divider; reset state and the no-calibration codes hold it still
    assign refm_divides = (refm_act_r >= REFM_DIV_MIN) && (refm_act_r <= REFM_DIV_MAX); // see R5

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            {refm_cnt_r, refm_tick_r} <= '0;
        else if (!refm_divides || upd_r)
        begin
            refm_cnt_r  <= '0;
            refm_tick_r <= 1'b0; // see R5
        end
        else if (refm_cnt_r >= refm_act_r - 4'h1)
        begin
            refm_cnt_r  <= '0;
            refm_tick_r <= 1'b1; // see R5
        end
        else
        begin
            refm_cnt_r  <= refm_cnt_r + 4'h1;
            refm_tick_r <= 1'b0;
        end
    end

    // A change of M asks for calibration unless it leaves or enters the reset state
    // or lands on a no-calibration code
    assign cal_trigger = upd_r
                      && (ref_m_r[REFM_W-1:0] != refm_act_r)
                      && (refm_act_r != REFM_RESET_STATE) // see R7
                      && (ref_m_r[REFM_W-1:0] != REFM_RESET_STATE)
                      && !((ref_m_r[REFM_W-1:0] >= REFM_NOCAL_MIN)
                           && (ref_m_r[REFM_W-1:0] <= REFM_NOCAL_MAX)); // see R6

    // A new request wins over a completion in the same cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cal_pend_r <= 1'b0;
        else if (cal_trigger)
            cal_pend_r <= 1'b1; // see R6
        else if (vco_cal_done)
            cal_pend_r <= 1'b0;
    end

    // Group A divider, powered down when every driver of the group is off
    assign drv0_off     = pd_act_r // see R16
                       || (mode_act_r == MODE_DISABLED); // see R12
    assign diva_powered = !(drv0_off && (&other_drivers_off)); // see R11

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            {diva_cnt_r, diva_tick_r} <= '0;
        else if (!diva_powered || upd_r)
        begin
            diva_cnt_r  <= '0;
            diva_tick_r <= 1'b0; // see R11
        end
        else if (diva_cnt_r >= diva_act_r)
        begin
            diva_cnt_r  <= '0;
            diva_tick_r <= 1'b1; // see R10
        end
        else
        begin
            diva_cnt_r  <= diva_cnt_r + 8'h01;
            diva_tick_r <= 1'b0;
        end
    end

    // Output driver; undefined modes are kept quiet rather than guessed
    always_comb
    begin
        cmos_mode = 1'b0;
        true_en   = 1'b0;
        comp_en   = 1'b0;
        case (mode_act_r)
            MODE_HSTL:      {cmos_mode, true_en, comp_en} = 3'h3; // see R12
            MODE_CMOS_BOTH: {cmos_mode, true_en, comp_en} = 3'h7; // see R13
            MODE_CMOS_TRUE: {cmos_mode, true_en, comp_en} = 3'h6; // see R13
            MODE_CMOS_COMP: {cmos_mode, true_en, comp_en} = 3'h5; // see R13
            default:        {cmos_mode, true_en, comp_en} = 3'h0; // see R12
        endcase
        if (pd_act_r)
        begin
            true_en = 1'b0; // see R16
            comp_en = 1'b0;
        end
    end

    // HSTL is always a true/complement pair; polarity only bends CMOS
    // Polarity bit 1 inverts the true pin, bit 0 lifts the complement's inversion
    assign true_inv = cmos_mode && pol_act_r[1];    // see R15
    assign comp_inv = !(cmos_mode && pol_act_r[0]); // see R14

    // Disabled pins park low so that nothing toggles behind a closed driver
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            {true_r, comp_r} <= 2'h0;
        else
        begin
            true_r <= true_en && (diva_tick_r ^ true_inv);
            comp_r <= comp_en && (diva_tick_r ^ comp_inv);
        end
    end

    assign reg_rdata                      = rdata_r;
    assign io_update_pulse                = upd_r;
    assign loop2_allowed                  = !(fb_act_r <= FB_BYPASS_MAX); // see R1
    assign feedback_b_bypass              = fb_bypass;
    assign feedback_b_tick                = fb_tick_r;
    assign reference_m_enabled            = refm_divides;
    assign reference_m_tick               = refm_tick_r;
    assign vco_cal_request                = cal_pend_r;
    assign group_a_divider_powered        = diva_powered;
    assign group_a_tick                   = diva_tick_r;
    assign first_output_true_pin          = true_r;
    assign first_output_true_pin_en       = true_en;
    assign first_output_complement_pin    = comp_r;
    assign first_output_complement_pin_en = comp_en;

endmodule

/* test/pdoc_props.sv */
`timescale 1ns/1ps
module pdoc_props
    import pdoc_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int DATA_WIDTH = DATA_W
)
(
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [DATA_WIDTH-1:0] reg_rdata,
    input wire logic [1:0]            loop_config,
    input wire logic [2:0]            other_drivers_off,
    input wire logic                  vco_cal_done,
    input wire logic                  io_update_pulse,
    input wire logic                  loop2_allowed,
    input wire logic                  feedback_b_bypass,
    input wire logic                  feedback_b_tick,
    input wire logic                  reference_m_enabled,
    input wire logic                  reference_m_tick,
    input wire logic                  vco_cal_request,
    input wire logic                  group_a_divider_powered,
    input wire logic                  group_a_tick,
    input wire logic                  first_output_true_pin,
    input wire logic                  first_output_true_pin_en,
    input wire logic                  first_output_complement_pin,
    input wire logic                  first_output_complement_pin_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_update_pulse: assert property (reg_wr && reg_addr == ADDR_IO_UPDATE && reg_wdata[0] |=> io_update_pulse)
        else $error("update pulse missing");
    chk_update_cause: assert property (io_update_pulse |-> $past(reg_wr) && $past(reg_addr) == ADDR_IO_UPDATE
        && $past(reg_wdata[0]))
        else $error("update pulse without cause");
    chk_loop4_bypass: assert property (loop_config == LOOP_CFG_4 |-> feedback_b_bypass)
        else $error("fourth loop config not bypassed");
    chk_loop2_bypass: assert property (!loop2_allowed |-> feedback_b_bypass)
        else $error("low feedback value not bypassed");
    chk_bypass_ticks: assert property ((feedback_b_bypass && !io_update_pulse) [*3] |-> feedback_b_tick)
        else $error("bypassed feedback divider not passing clock");
    chk_group_alive: assert property (!(&other_drivers_off) |-> group_a_divider_powered)
        else $error("group divider off while a driver is on");
    chk_group_quiet: assert property (!group_a_divider_powered [*2] |-> !group_a_tick)
        else $error("group divider ticks while powered down");
    chk_true_quiet: assert property (!first_output_true_pin_en [*2] |-> !first_output_true_pin)
        else $error("disabled true pin toggles");
    chk_refm_quiet: assert property (!reference_m_enabled [*2] |-> !reference_m_tick)
        else $error("disabled reference divider ticks");
    chk_cal_cause: assert property ($rose(vco_cal_request) |-> $past(io_update_pulse))
        else $error("calibration request without update");
endmodule

bind pdoc_top pdoc_props #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) u_props (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .loop_config(loop_config), .other_drivers_off(other_drivers_off),
    .vco_cal_done(vco_cal_done), .io_update_pulse(io_update_pulse), .loop2_allowed(loop2_allowed),
    .feedback_b_bypass(feedback_b_bypass), .feedback_b_tick(feedback_b_tick),
    .reference_m_enabled(reference_m_enabled), .reference_m_tick(reference_m_tick),
    .vco_cal_request(vco_cal_request), .group_a_divider_powered(group_a_divider_powered),
    .group_a_tick(group_a_tick), .first_output_true_pin(first_output_true_pin),
    .first_output_true_pin_en(first_output_true_pin_en), .first_output_complement_pin(first_output_complement_pin),
    .first_output_complement_pin_en(first_output_complement_pin_en));

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
    import pdoc_pkg::*;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, v;
    logic [7:0]  exp_q[$];
    logic [2:0]  other_drivers_off;
    logic [1:0]  loop_config;
    logic        clock, rst, reg_wr, reg_rd, vco_cal_done, rd_pend, et, ec;
    logic        io_update_pulse, loop2_allowed, feedback_b_bypass, feedback_b_tick, reference_m_enabled;
    logic        reference_m_tick, vco_cal_request, group_a_divider_powered, group_a_tick;
    logic        first_output_true_pin, first_output_true_pin_en;
    logic        first_output_complement_pin, first_output_complement_pin_en;
    logic [2:0]  modes[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
    int          mismatches, n_checks, p, n, m, pl;

    pdoc_top uut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .loop_config(loop_config), .other_drivers_off(other_drivers_off),
        .vco_cal_done(vco_cal_done), .io_update_pulse(io_update_pulse), .loop2_allowed(loop2_allowed),
        .feedback_b_bypass(feedback_b_bypass), .feedback_b_tick(feedback_b_tick),
        .reference_m_enabled(reference_m_enabled), .reference_m_tick(reference_m_tick),
        .vco_cal_request(vco_cal_request), .group_a_divider_powered(group_a_divider_powered),
        .group_a_tick(group_a_tick), .first_output_true_pin(first_output_true_pin),
        .first_output_true_pin_en(first_output_true_pin_en),
        .first_output_complement_pin(first_output_complement_pin),
        .first_output_complement_pin_en(first_output_complement_pin_en));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One access per call; the strobe drops at the next edge so no edge sees two assignments
    task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(a, 8'h00, 1'b0);
    endtask

    task automatic upd(input logic [15:0] a, input logic [7:0] d);
        acc(a, d, 1'b1);
        acc(ADDR_IO_UPDATE, 8'h01, 1'b1);
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic cal_clear();
        @(posedge clock);
        vco_cal_done <= 1'b1;
        @(posedge clock);
        vco_cal_done <= 1'b0;
    endtask

    function automatic logic tk(input int s);
        return s == 0 ? feedback_b_tick : (s == 1 ? reference_m_tick : group_a_tick);
    endfunction

    // Cycles between two ticks; a tick stuck high gives 1
    task automatic per(input int s, output int q);
        q = 0;
        for (int i = 0; i < 1000 && !tk(s); i++)
        begin
            @(posedge clock);
            #1;
        end
        do
        begin
            @(posedge clock);
            #1;
            q++;
        end while (!tk(s) && q < 1000);
    endtask

    always @(posedge clock)
    begin
        #1;
        if (rd_pend)
            check("reg_rdata", 16'(reg_rdata), 16'(exp_q.pop_front()));
        rd_pend = reg_rd;
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        {mismatches, n_checks, rd_pend, reg_wr, reg_rd, vco_cal_done} = '0;
        {reg_addr, reg_wdata, loop_config, other_drivers_off} = '0;
        rst = 1'b1;
        void'($urandom(32'hED88));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        foreach (modes[i])
            rd(16'h010D + 16'(i), 8'h00);
        acc(16'h0200, 8'hA5, 1'b1);
        rd(16'h0200, 8'h00);
        acc(ADDR_FB_HIGH, 8'hF1, 1'b1);
        rd(ADDR_FB_HIGH, 8'h01);
        acc(ADDR_OUT0_CFG, 8'hE3, 1'b1);
        rd(ADDR_OUT0_CFG, 8'h23);
        $display("register map test done");
        acc(ADDR_FB_LOW, 8'h09, 1'b1);
        acc(ADDR_IO_UPDATE, 8'hFE, 1'b1);
        repeat (4) @(posedge clock);
        #1;
        check("bypass no update", 16'(feedback_b_bypass), 16'h1);
        for (n = 0; n < 2; n++)
        begin
            acc(ADDR_FB_LOW, 8'(n), 1'b1);
            upd(ADDR_FB_HIGH, 8'h00);
            check("bypass", 16'(feedback_b_bypass), 16'h1);
            check("loop2", 16'(loop2_allowed), 16'h0);
        end
        acc(ADDR_FB_LOW, 8'h05, 1'b1);
        upd(ADDR_FB_HIGH, 8'hF1);
        check("loop2", 16'(loop2_allowed), 16'h1);
        per(0, p);
        check("fb period", 16'(p), 16'h0105);
        n = 4 + $urandom % 250;
        acc(ADDR_FB_LOW, 8'(n), 1'b1);
        upd(ADDR_FB_HIGH, 8'h00);
        per(0, p);
        check("fb period", 16'(p), 16'(n));
        @(posedge clock);
        loop_config <= LOOP_CFG_4;
        per(0, p);
        check("fb loop4", 16'(p), 16'h1);
        @(posedge clock);
        loop_config <= 2'h0;
        $display("feedback divider test done");
        for (m = 0; m < 16; m++)
        begin
            upd(ADDR_REF_M, 8'(m));
            check("m enabled", 16'(reference_m_enabled), 16'(m >= 3 && m <= 11));
            check("cal request", 16'(vco_cal_request), 16'(m >= 1 && m <= 11));
            if (m == 3 || m == 11)
            begin
                per(1, p);
                check("m period", 16'(p), 16'(m));
            end
            cal_clear();
            #1;
            check("cal cleared", 16'(vco_cal_request), 16'h0);
        end
        upd(ADDR_REF_M, 8'h05);
        check("cal after reset state", 16'(vco_cal_request), 16'h0);
        $display("reference divider test done");
        @(posedge clock);
        other_drivers_off <= 3'h7;
        acc(ADDR_DIV_A, 8'h00, 1'b1);
        upd(ADDR_OUT0_CFG, 8'h21);
        check("powered pd", 16'(group_a_divider_powered), 16'h0);
        check("en pd", 16'(first_output_true_pin_en), 16'h0);
        upd(ADDR_OUT0_CFG, 8'h00);
        check("powered mode0", 16'(group_a_divider_powered), 16'h0);
        upd(ADDR_OUT0_CFG, 8'h20);
        check("powered on", 16'(group_a_divider_powered), 16'h1);
        per(2, p);
        check("a period zero", 16'(p), 16'h1);
        foreach (modes[i])
            for (pl = 0; pl < 4; pl++)
            begin
                upd(ADDR_OUT0_CFG, {2'b00, modes[i], 2'(pl), 1'b0});
                et = modes[i] == 3'h1 || modes[i] == 3'h4 || modes[i] == 3'h5;
                ec = modes[i] == 3'h1 || modes[i] == 3'h4 || modes[i] == 3'h6;
                check("true en", 16'(first_output_true_pin_en), 16'(et));
                check("comp en", 16'(first_output_complement_pin_en), 16'(ec));
                check("true pin", 16'(first_output_true_pin), 16'(et & (modes[i] == 3'h1 | !pl[1])));
                check("comp pin", 16'(first_output_complement_pin), 16'(ec & modes[i] != 3'h1 & pl[0]));
            end
        $display("driver test done");
        v = 8'($urandom % 6 + 1);
        acc(ADDR_DIV_A, v, 1'b1);
        upd(ADDR_OUT0_CFG, 8'h20);
        per(2, p);
        check("a period", 16'(p), 16'(v) + 16'h1);
        @(posedge clock);
        other_drivers_off <= 3'($urandom % 7);
        upd(ADDR_OUT0_CFG, 8'h21);
        check("powered others", 16'(group_a_divider_powered), 16'h1);
        $display("group divider test done");
        repeat (3) @(posedge clock);
        print_verdict();
    end
endmodule
